// file: rtl/adc_cmd_pkg.sv
// Types shared by the serial command decoder and its converter engine.
// Assumes the constants header supplies every count and position.
package adc_cmd_pkg;

    // Command nibble codes above the channel range
    typedef enum logic [3:0] {
        CMD_PWRDN   = 4'h8,
        CMD_CFG_RD  = 4'h9,
        CMD_CFG_WR  = 4'ha,
        CMD_TST_MID = 4'hb,
        CMD_TST_LO  = 4'hc,
        CMD_TST_HI  = 4'hd,
        CMD_FIFO_RD = 4'he,
        CMD_RSVD    = 4'hf
    } cmd_e;

    // One received input word
    typedef struct packed {
        logic [3:0]  command_nibble;
        logic [11:0] data;
    } rx_word_s;

    // Multiplexer drive: sel 0-7 channels, b-d test inputs
    typedef struct packed {
        logic       en;
        logic [3:0] sel;
    } mux_s;

    // Converter engine states, Gray coded
    typedef enum logic {
        SAR_IDLE = 1'b0,
        SAR_STEP = 1'b1
    } sar_e;

endpackage : adc_cmd_pkg

// file: rtl/adc_cmd_regs.svh
// Timing counts, field positions and reset values of the serial command decoder.
// Assumes a 100 ns system clock; included by bare name from the design files.
// Function
// - 16-bit word: command nibble then data
// - Most commands use the nibble alone
// - Codes 0h-7h select analog channels
// - Code 8h enters software power down
// - Code 9h returns configuration word
// - Code Ah stores twelve data bits
// - Codes Bh-Dh select test voltages
// - Code Eh reads result, low nibble zero
// - Config read: word in low twelve bits
// - Result in bits 15-4, rest don't-care
// - Straight binary result code
// - First conversion after power-up flagged invalid
// - Chip select fall starts cycle, sync high
// - Frame sync fall starts DSP cycle
// - Configuration kept through power down
// - Clock may pause mid word
// - Multiplexer breaks before it makes
// - Twelve-step successive approximation
// - Sample rising edge, falling in DSP
// - Output floats after sixteenth bit
`ifndef ADC_CMD_REGS_SVH
`define ADC_CMD_REGS_SVH

`define WORD_BITS    16
`define CMD_POS      12
`define RESULT_POS   4
`define CFG_RESET    12'h000
`define SYS_CLK_NS   100
`define BBM_NS       200
`define BBM_CYC      ((`BBM_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define SETTLE_NS    300
`define SETTLE_CYC   ((`SETTLE_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)

`endif

// file: rtl/adc_serial_command_decoder.sv
// Serial command front end: shifts in 16-bit words, decodes commands, shifts out results.
// Assumes sclk idles low between frames; cs_n high ends every chip-select frame, sync framing may hold it low.
`timescale 1ns/1ps
`include "adc_cmd_regs.svh"

module adc_serial_command_decoder (
    // System clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // Serial link
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        frame_sync,
    input  wire logic        serial_in,
    output logic             serial_out,
    output logic             serial_out_oe,
    // Analog side
    input  wire logic        comp_in,
    output adc_cmd_pkg::mux_s mux_q,
    output logic             power_down_q,
    output logic [11:0]      sar_dac,
    // Status
    output logic [11:0]      config_word_reg,
    output logic             conv_done,
    output logic             result_invalid_q
);

    localparam logic [4:0] WORD_LAST = 5'(`WORD_BITS - 1);
    localparam logic [4:0] WORD_FULL = 5'(`WORD_BITS);
    localparam logic [2:0] BBM_LOAD  = 3'(`BBM_CYC);

    // ---------------- link domain (sclk) ----------------
    logic                  link_rst_n;
    logic                  sdi_n_q;
    logic                  fs_n_q;
    logic                  fs_p_q;
    logic                  first_q;
    logic                  dsp_q;
    logic [4:0]            cnt_q;
    logic [14:0]           sr_q;
    adc_cmd_pkg::rx_word_s word_q;
    logic                  word_tgl_q;
    logic [15:0]           tx_q;
    logic                  over_q;
    logic                  spi_start;
    logic                  dsp_start;
    logic                  restart;
    logic                  take;
    logic                  bit_in;
    logic [15:0]           resp_q;

    // Frame ends when select rises
    assign link_rst_n = rst_n & ~cs_n;

    assign spi_start = ~first_q & frame_sync;
    // sync falling edge in DSP mode
    assign dsp_start = first_q & dsp_q & fs_p_q & ~fs_n_q;
    assign restart   = spi_start | dsp_start;
    // counting waits for a frame start and stops after 16 bits
    assign take      = restart | (first_q & (cnt_q != 5'h0) & (cnt_q != WORD_FULL));
    // falling-edge sample used in DSP mode
    assign bit_in    = dsp_q ? sdi_n_q : serial_in;

    // Falling-edge capture of data and sync
    always_ff @(negedge sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            sdi_n_q <= 1'b0;
            fs_n_q  <= 1'b0;
        end else begin
            sdi_n_q <= serial_in;
            fs_n_q  <= frame_sync;
        end
    end

    // Mode latch: sync low at the first edge selects DSP framing
    always_ff @(posedge sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            first_q <= 1'b0;
            dsp_q   <= 1'b0;
            fs_p_q  <= 1'b0;
        end else begin
            first_q <= 1'b1;
            fs_p_q  <= fs_n_q;
            if (!first_q) begin
                dsp_q <= ~frame_sync;
            end
        end
    end

    // MSB-first shift into a 16-bit word
    always_ff @(posedge sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            cnt_q <= 5'h0;
            sr_q  <= 15'h0;
        end else if (restart) begin
            cnt_q <= 5'h1;
            sr_q  <= {14'h0, bit_in};
        end else if (take) begin
            cnt_q <= cnt_q + 5'h1;
            sr_q  <= {sr_q[13:0], bit_in};
        end
    end

    // Completed word handed over by toggle; word_q stays until the next word
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            word_q     <= '0;
            word_tgl_q <= 1'b0;
        end else if (cs_n == 1'b0 && take && !restart && cnt_q == WORD_LAST) begin
            word_q     <= {sr_q, bit_in};
            word_tgl_q <= ~word_tgl_q;
        end
    end

    // Response word latched at frame start; extra edges after 16 bits end the output
    always_ff @(posedge sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            tx_q   <= 16'h0;
            over_q <= 1'b0;
        end else begin
            if (restart) begin
                tx_q   <= resp_q;
                over_q <= 1'b0;
            end else if (cnt_q == WORD_FULL) begin
                over_q <= 1'b1;
            end
        end
    end

    // output floats after the sixteenth bit
    always_ff @(negedge sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            serial_out    <= 1'b0;
            serial_out_oe <= 1'b0;
        end else begin
            serial_out_oe <= (cnt_q != 5'h0) && !over_q && !restart;
            serial_out    <= tx_q[4'(WORD_FULL - cnt_q)];
        end
    end

    // ---------------- system domain ----------------
    logic                  tgl_s1_q;
    logic                  tgl_s2_q;
    logic                  tgl_s3_q;
    logic                  comp_s1_q;
    logic                  comp_s2_q;
    logic                  new_word;
    adc_cmd_pkg::cmd_e     cmd;
    logic                  is_sel;
    logic                  resp_cfg_q;
    logic [3:0]            pend_q;
    logic [2:0]            bbm_q;
    logic                  start_q;
    logic                  first_conv_q;
    logic [11:0]           result;
    logic                  done;
    logic                  seen_q;

    // Toggle and comparator synchronisers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tgl_s1_q  <= 1'b0;
            tgl_s2_q  <= 1'b0;
            tgl_s3_q  <= 1'b0;
            comp_s1_q <= 1'b0;
            comp_s2_q <= 1'b0;
        end else begin
            tgl_s1_q  <= word_tgl_q;
            tgl_s2_q  <= tgl_s1_q;
            tgl_s3_q  <= tgl_s2_q;
            comp_s1_q <= comp_in;
            comp_s2_q <= comp_s1_q;
        end
    end

    // decode acts on the nibble alone
    assign new_word = tgl_s2_q ^ tgl_s3_q;
    assign cmd      = adc_cmd_pkg::cmd_e'(word_q.command_nibble);
    assign is_sel   = (word_q.command_nibble < 4'h8) || (cmd == adc_cmd_pkg::CMD_TST_MID)
                      || (cmd == adc_cmd_pkg::CMD_TST_LO) || (cmd == adc_cmd_pkg::CMD_TST_HI);

    // configuration write, kept through power down
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            config_word_reg <= `CFG_RESET;
        end else if (new_word && cmd == adc_cmd_pkg::CMD_CFG_WR) begin
            config_word_reg <= word_q.data;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            power_down_q <= 1'b0;
        end else if (new_word && cmd == adc_cmd_pkg::CMD_PWRDN) begin
            power_down_q <= 1'b1;
        end else if (new_word && cmd != adc_cmd_pkg::CMD_RSVD) begin
            power_down_q <= 1'b0;
        end
    end

    // read selects config response; FIFO read selects result
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            resp_cfg_q <= 1'b0;
        end else if (new_word && cmd == adc_cmd_pkg::CMD_CFG_RD) begin
            resp_cfg_q <= 1'b1;
        end else if (new_word && (is_sel || cmd == adc_cmd_pkg::CMD_FIFO_RD)) begin
            resp_cfg_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            resp_q <= 16'h0;
        end else if (resp_cfg_q) begin
            resp_q <= {4'h0, config_word_reg};
        end else begin
            resp_q <= {result, 4'h0};
        end
    end

    // disconnect, wait, then connect the new input
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mux_q   <= '0;
            pend_q  <= 4'h0;
            bbm_q   <= 3'h0;
            start_q <= 1'b0;
        end else begin
            start_q <= 1'b0;
            if (new_word && is_sel) begin
                mux_q.en <= 1'b0;
                pend_q   <= word_q.command_nibble;
                bbm_q    <= BBM_LOAD;
            end else if (bbm_q != 3'h0) begin
                bbm_q <= bbm_q - 3'h1;
                if (bbm_q == 3'h1) begin
                    mux_q.sel <= pend_q;
                    mux_q.en  <= 1'b1;
                    start_q   <= 1'b1;
                end
            end
        end
    end

    sar_engine u_sar (
        .clk      (sys_clk),
        .rst_n    (rst_n),
        .start    (start_q),
        .comp_hi  (comp_s2_q),
        .dac_q    (sar_dac),
        .result_q (result),
        .done_q   (done)
    );

    assign conv_done = done;

    // first conversion after reset or power down flagged
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            first_conv_q     <= 1'b1;
            result_invalid_q <= 1'b0;
        end else begin
            if (power_down_q) begin
                first_conv_q <= 1'b1;
            end else if (done) begin
                first_conv_q <= 1'b0;
            end
            if (done) begin
                result_invalid_q <= first_conv_q;
            end
        end
    end

    // Helper: a conversion has completed since reset or power down
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            seen_q <= 1'b0;
        end else if (power_down_q) begin
            seen_q <= 1'b0;
        end else if (done) begin
            seen_q <= 1'b1;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_cmd(adc_cmd_pkg::cmd_e c);
        new_word && cmd == c;
    endsequence

    sequence s_break_make;
        !mux_q.en [*2] ##1 (mux_q.en && start_q);
    endsequence

    property p_pwrdn;
        s_cmd(adc_cmd_pkg::CMD_PWRDN) |=> power_down_q;
    endproperty
    a_pwrdn: assert property (p_pwrdn) else $error("power down not entered");

    property p_cfg_wr;
        s_cmd(adc_cmd_pkg::CMD_CFG_WR) |=> config_word_reg == $past(word_q.data);
    endproperty
    a_cfg_wr: assert property (p_cfg_wr) else $error("configuration not stored");

    property p_cfg_keep;
        !(new_word && cmd == adc_cmd_pkg::CMD_CFG_WR) |=> $stable(config_word_reg);
    endproperty
    a_cfg_keep: assert property (p_cfg_keep) else $error("configuration changed without write");

    property p_rsvd;
        s_cmd(adc_cmd_pkg::CMD_RSVD) |=> $stable(config_word_reg) && $stable(power_down_q) && $stable(mux_q);
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved command had an effect");

    property p_select;
        (new_word && is_sel) |=> s_break_make;
    endproperty
    a_select: assert property (p_select) else $error("input not connected after break");

    property p_bbm;
        $changed(mux_q.sel) |-> !$past(mux_q.en);
    endproperty
    a_bbm: assert property (p_bbm) else $error("select changed while connected");

    property p_cfg_rd;
        s_cmd(adc_cmd_pkg::CMD_CFG_RD) |=> ##1 resp_q == {4'h0, config_word_reg};
    endproperty
    a_cfg_rd: assert property (p_cfg_rd) else $error("config response wrong");

    property p_fifo;
        s_cmd(adc_cmd_pkg::CMD_FIFO_RD) |=> ##1 resp_q == {result, 4'h0};
    endproperty
    a_fifo: assert property (p_fifo) else $error("result response wrong");

    property p_invalid;
        (done && !seen_q && !power_down_q) |=> result_invalid_q;
    endproperty
    a_invalid: assert property (p_invalid) else $error("first conversion not flagged");

endmodule : adc_serial_command_decoder

// file: rtl/sar_engine.sv
// Successive approximation sequencer: drives the trial code, reads the comparator.
// Assumes comp_hi is already synchronised to clk and means input >= trial code.
`timescale 1ns/1ps
`include "adc_cmd_regs.svh"

module sar_engine (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Control
    input  wire logic        start,
    input  wire logic        comp_hi,
    // Results
    output logic [11:0]      dac_q,
    output logic [11:0]      result_q,
    output logic             done_q
);

    localparam logic [1:0] SETTLE_LAST = 2'(`SETTLE_CYC - 1);

    adc_cmd_pkg::sar_e state_q;
    logic [3:0]        bit_q;
    logic [1:0]        wait_q;
    logic [11:0]       mask;
    logic [11:0]       decided;
    logic              step_end;

    // Trial bit kept or dropped at the end of each settle window
    assign mask     = 12'h001 << bit_q;
    assign decided  = comp_hi ? dac_q : (dac_q & ~mask);
    assign step_end = (state_q == adc_cmd_pkg::SAR_STEP) && (wait_q == SETTLE_LAST);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= adc_cmd_pkg::SAR_IDLE;
            bit_q   <= 4'h0;
            wait_q  <= 2'h0;
            dac_q   <= 12'h000;
        end else begin
            unique case (state_q)
                adc_cmd_pkg::SAR_IDLE: begin
                    if (start) begin
                        state_q <= adc_cmd_pkg::SAR_STEP;
                        bit_q   <= 4'hb;
                        wait_q  <= 2'h0;
                        dac_q   <= 12'h800;
                    end
                end
                adc_cmd_pkg::SAR_STEP: begin
                    if (step_end) begin
                        wait_q <= 2'h0;
                        if (bit_q == 4'h0) begin
                            state_q <= adc_cmd_pkg::SAR_IDLE;
                            dac_q   <= decided;
                        end else begin
                            bit_q <= bit_q - 4'h1;
                            dac_q <= decided | (mask >> 1);
                        end
                    end else begin
                        wait_q <= wait_q + 2'h1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result_q <= 12'h000;
            done_q   <= 1'b0;
        end else begin
            done_q <= step_end && (bit_q == 4'h0);
            if (step_end && (bit_q == 4'h0)) begin
                result_q <= decided;
            end
        end
    end

    property p_sar_len;
        @(posedge clk) disable iff (!rst_n)
        (start && state_q == adc_cmd_pkg::SAR_IDLE) |-> ##37 done_q;
    endproperty
    a_sar_len: assert property (p_sar_len) else $error("conversion did not finish in 37 cycles");

endmodule : sar_engine

// file: sim/host_model.sv
// Host side of the serial link: makes the link clock and shifts whole 16-bit words.
// Assumes the decoder samples on rising edges in chip-select framing, falling edges in sync framing.
`timescale 1ns/1ps

module host_model (
    // Link outputs toward the decoder
    output logic      sclk,
    output logic      cs_n,
    output logic      frame_sync,
    output logic      serial_in,
    // Response from the decoder
    input  wire logic serial_out,
    input  wire logic serial_out_oe
);

    // Link clock stands low outside frames
    initial begin
        sclk       = 1'b0;
        cs_n       = 1'b1;
        frame_sync = 1'b1;
        serial_in  = 1'b0;
    end

    // One frame; rsp gathers the 16 response bits, oe_ok reports the output enable window
    task automatic xfer(input logic [15:0] w, input bit dsp, input bit pause,
                        output logic [15:0] rsp, output bit oe_ok);
        int i;
        oe_ok = 1'b1;
        rsp   = '0;
        // sync framing may keep select low
        if (!dsp || cs_n) begin
            cs_n       = 1'b1;
            frame_sync = !dsp;
            #200;
            cs_n       = 1'b0;
            #40;
        end
        // Sync framing: one edge with sync low picks the mode, then a one-clock sync pulse.
        // Levels change mid-way through the low phase, clear of both clock edges.
        if (dsp) begin
            #16 frame_sync = 1'b0;
            #16 sclk = 1'b1;
            #32 sclk = 1'b0;
            #16 frame_sync = 1'b1;
            #16 sclk = 1'b1;
            #32 sclk = 1'b0;
            #16 frame_sync = 1'b0;
        end
        // MSB first, zero padding; sync framing answers one clock later
        for (i = 0; i < 17 + dsp; i++) begin
            #16 serial_in = (i < 16) ? w[15-i] : 1'b0;
            #16 sclk = 1'b1;
            if (i > dsp) begin
                rsp[16-i+dsp] = serial_out;
                if (serial_out_oe !== 1'b1) oe_ok = 1'b0;
            end
            #32 sclk = 1'b0;
            if (pause && i == 7) #700;
        end
        // Released data line shows the inverse of its last value
        serial_in = ~serial_in;
        #40;
        if (!dsp) cs_n = 1'b1;
        #100;
        if (serial_out_oe !== 1'b0) oe_ok = 1'b0;
        #1000;
    endtask : xfer

endmodule : host_model

// file: sim/testbench.sv
// Self-checking bench for the serial command decoder with a host model and a comparator model.
// Assumes the decoder's hand-over timing: one-frame response latency, conversion under 300 cycles.
`timescale 1ns/1ps

module testbench;

    logic              sys_clk, rst_n, sclk, cs_n, frame_sync, serial_in, serial_out, serial_out_oe;
    logic              comp_in, power_down_q, conv_done, result_invalid_q;
    logic [11:0]       sar_dac, config_word_reg, vin;
    adc_cmd_pkg::mux_s mux_q, mux_prev;
    logic [15:0]       rsp;
    int                failures, checks, convs;

    adc_serial_command_decoder DUT (
        .sys_clk(sys_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .frame_sync(frame_sync),
        .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
        .comp_in(comp_in), .mux_q(mux_q), .power_down_q(power_down_q), .sar_dac(sar_dac),
        .config_word_reg(config_word_reg), .conv_done(conv_done), .result_invalid_q(result_invalid_q)
    );

    host_model host (
        .sclk(sclk), .cs_n(cs_n), .frame_sync(frame_sync), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe)
    );

    // Comparator: high while the input level is at or above the trial code
    assign comp_in = (vin >= sar_dac);

    // System clock
    always #50 sys_clk = ~sys_clk;

    // Count conversions; a channel never connects straight after another one
    always @(posedge sys_clk) begin
        if (conv_done === 1'b1) convs++;
        if (mux_q.en === 1'b1 && mux_prev.en === 1'b1 && mux_q.sel !== mux_prev.sel) cmp_bit(1'b0, 1'b1);
        mux_prev <= mux_q;
    end

    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_word

    task automatic cmp_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_bit

    // One host frame; the output enable window is judged every time
    task automatic frame(input logic [15:0] w, input bit dsp = 0, input bit pause = 0);
        bit ok;
        host.xfer(w, dsp, pause, rsp, ok);
        cmp_bit(ok, 1'b1);
    endtask : frame

    // Bounded wait for a conversion begun after count n0, then let flags settle
    task automatic wait_conv(input int n0);
        int k;
        for (k = 0; k < 300 && convs == n0; k++) @(posedge sys_clk);
        cmp_bit(convs != n0, 1'b1);
        repeat (2) @(posedge sys_clk);
    endtask : wait_conv

    task automatic t_init;
        cmp_word({1'b0, mux_q.en, power_down_q, serial_out_oe, config_word_reg}, 16'h0000);
        frame(16'ha000);
        cmp_word({4'h0, config_word_reg}, 16'h0000);
    endtask : t_init

    task automatic t_cfg;
        frame(16'ha593);
        cmp_word({4'h0, config_word_reg}, 16'h0593);
        frame(16'h9000);
        frame(16'hf000);
        cmp_word({4'h0, rsp[11:0]}, 16'h0593);
    endtask : t_cfg

    // Every selection code in turn; each frame after the first returns the previous result
    task automatic t_chan;
        logic [11:0] prev;
        logic [3:0]  c;
        int          n0;
        for (int i = 0; i < 11; i++) begin
            c    = (i < 8) ? i[3:0] : 4'(i + 3);
            prev = vin;
            vin  = (c == 4'hd) ? 12'hfff : {c, c, c};
            n0   = convs;
            frame({c, 12'h000});
            if (i > 0) cmp_word({rsp[15:4], 4'h0}, {prev, 4'h0});
            wait_conv(n0);
            cmp_word({11'h0, mux_q}, {11'h0, 1'b1, c});
            cmp_bit(result_invalid_q, i == 0);
        end
        frame(16'he000);
        frame(16'hf000);
        cmp_word(rsp, 16'hfff0);
    endtask : t_chan

    task automatic t_pwrdn;
        int n0;
        frame(16'h8000);
        cmp_bit(power_down_q, 1'b1);
        cmp_word({4'h0, config_word_reg}, 16'h0593);
        n0 = convs;
        frame(16'h3000);
        wait_conv(n0);
        cmp_bit(power_down_q, 1'b0);
        cmp_bit(result_invalid_q, 1'b1);
    endtask : t_pwrdn

    task automatic t_rsvd;
        adc_cmd_pkg::mux_s m;
        int                n0;
        m  = mux_q;
        n0 = convs;
        frame(16'hfabc);
        repeat (60) @(posedge sys_clk);
        cmp_word({4'h0, config_word_reg}, 16'h0593);
        cmp_word({10'h0, power_down_q, mux_q}, {10'h0, 1'b0, m});
        cmp_bit(convs == n0, 1'b1);
    endtask : t_rsvd

    task automatic t_dsp;
        frame(16'ha00f, 1);
        cmp_word({4'h0, config_word_reg}, 16'h000f);
        cmp_word(rsp, 16'hfff0);
        frame(16'h9000, 1);
        frame(16'hf000, 1);
        cmp_word({4'h0, rsp[11:0]}, 16'h000f);
    endtask : t_dsp

    task automatic t_pause;
        frame(16'ha0c3, 0, 1);
        cmp_word({4'h0, config_word_reg}, 16'h00c3);
    endtask : t_pause

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : finish_test

    // Reset, then each scenario in turn
    initial begin
        sys_clk  = 1'b0;
        rst_n    = 1'b0;
        vin      = 12'h000;
        mux_prev = '0;
        failures = 0;
        checks   = 0;
        convs    = 0;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        t_init;
        t_cfg;
        t_chan;
        t_pwrdn;
        t_rsvd;
        t_dsp;
        t_pause;
        finish_test;
    end

    // Watchdog well beyond the expected run
    initial begin
        #2000000;
        failures++;
        finish_test;
    end

endmodule : testbench
